// [rtl/flash_ctrl_pkg.sv]
// Constants, enumerations and carrier structs of the flash sequencer
package flash_ctrl_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ = 250;
	localparam logic [7:0] USEC_RELOAD_RST = 8'(CLK_MHZ - 1);
	localparam int US_CNT_W = 18;

	// ==========================================================
	// Control word layout
	localparam logic [15:0] CTRL_KEY = 16'ha442;
	localparam int CTRL_WRITE = 0;
	localparam int CTRL_ERASE = 1;
	localparam int CTRL_MASS = 2;
	localparam int CTRL_COMMIT = 3;
	localparam int MASK_ACCESS = 0;

	// ==========================================================
	// Array geometry (256 KB, 1 KB pages, 2 KB protection blocks)
	localparam int BYTE_ADDR_W = 18;
	localparam int WORD_ADDR_W = 16;
	localparam int PAGE_W = 8;
	localparam int BLOCK_W = 7;
	localparam int PAGE_LSB = 10;
	localparam int BLOCK_LSB = 11;
	localparam int PROT_REGS = 4;

	// ==========================================================
	// Commit target addresses
	localparam logic [31:0] COMMIT_RDEN0 = 32'h0000_0000;
	localparam logic [31:0] COMMIT_RDEN1 = 32'h0000_0002;
	localparam logic [31:0] COMMIT_RDEN2 = 32'h0000_0004;
	localparam logic [31:0] COMMIT_RDEN3 = 32'h0000_0008;
	localparam logic [31:0] COMMIT_PGEN0 = 32'h0000_0001;
	localparam logic [31:0] COMMIT_PGEN1 = 32'h0000_0003;
	localparam logic [31:0] COMMIT_PGEN2 = 32'h0000_0005;
	localparam logic [31:0] COMMIT_PGEN3 = 32'h0000_0007;
	localparam logic [31:0] COMMIT_USER0 = 32'h8000_0000;
	localparam logic [31:0] COMMIT_USER1 = 32'h8000_0001;
	localparam logic [31:0] COMMIT_DBG = 32'h7510_0000;

	// ==========================================================
	// Reset and factory values
	localparam logic [31:0] PROT_RST = 32'hffff_ffff;
	localparam logic [31:0] USER_RST = 32'hffff_ffff;
	localparam logic [31:0] DBG_RST = 32'hffff_fffe;
	localparam int NOT_WRITTEN_BIT = 31;

	// ==========================================================
	// Enumerations
	typedef enum logic [3:0] {
		SEL_ADDR = 4'h0,
		SEL_DATA = 4'h1,
		SEL_CTRL = 4'h2,
		SEL_USEC = 4'h3,
		SEL_MASK = 4'h4,
		SEL_READEN = 4'h5,
		SEL_PROGEN = 4'h6,
		SEL_USER0 = 4'h7,
		SEL_USER1 = 4'h8
	} reg_sel_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PROG_RD = 3'h1,
		ST_PROG = 3'h2,
		ST_ERASE = 3'h3,
		ST_MASS = 3'h4,
		ST_COMMIT = 3'h5
	} seq_state_t;

	typedef enum logic [1:0] {
		TGT_RDEN = 2'h0,
		TGT_PGEN = 2'h1,
		TGT_USER = 2'h2,
		TGT_DBG = 2'h3
	} commit_kind_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic en;
		reg_sel_t sel;
		logic [1:0] idx;
		logic [31:0] data;
	} sw_write_t;

	typedef struct packed {
		logic req;
		logic fetch;
		logic [BYTE_ADDR_W-1:0] addr;
	} data_read_t;

	typedef struct packed {
		logic valid;
		logic refused;
		logic [31:0] data;
	} read_answer_t;

	typedef struct packed {
		logic prog;
		logic page_erase;
		logic mass_erase;
		logic [WORD_ADDR_W-1:0] word_addr;
		logic [31:0] wdata;
		logic [PAGE_W-1:0] page;
	} array_cmd_t;

	typedef struct packed {
		logic valid;
		commit_kind_t kind;
		logic [1:0] idx;
	} commit_target_t;

endpackage

// [rtl/usec_tick.sv]
// Microsecond tick generator reloaded from the cycles-per-microsecond value minus one
`timescale 1ns/100ps
`default_nettype none
module usec_tick (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Reload value and tick
	input wire logic [7:0] reload,
	output logic tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} tick_state_t;

	tick_state_t s;
	tick_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == 8'h00) begin
			next_s.cnt = reload;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt - 8'h01;
		end
		if (rst) begin
			next_s.cnt = reload;
			next_s.tick = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	assign tick = s.tick;
endmodule
`default_nettype wire

// [rtl/flash_program_protect_ctrl.sv]
// Flash program/erase/commit sequencer with per-block protection
// Operation
// - Erase works on 1 KB pages and leaves every bit of the page set.
// - Programming writes one 32-bit word and can only clear bits.
// - Protection works on 2 KB blocks, each with program and read enable bits.
// - Reset loads microsecond count suited to the highest clock rate.
// - Program enable one allows change; zero keeps the block contents fixed.
// - Read enable zero leaves the block reachable by instruction fetch only.
// - Program on, read off allows change and fetch; both on allows everything.
// - Change of a program-protected block is blocked; masked violation interrupt.
// - Data read of a read-protected block is refused and returns zeros.
// - Factory protection bits are all ones, fully open.
// - Protection writes act at once; uncommitted clears undone by power-on reset.
// - Page erase: address, keyed erase; erase bit high until done.
// - Mass erase: keyed mass erase; bit high until whole array erased.
// - Nonvolatile registers sit outside the array, untouched by erases.
// - Keyed commit starts nonvolatile write; commit bit high until done.
// - Debug word commits data register; others commit their own contents.
// - Nonvolatile bits only ever go from one to zero.
// - User and debug words commit once via bit 31; protection repeatedly.
// - Commit target chosen from the address register value.
// - Write and erase bits read one while running, zero when done.
`timescale 1ns/100ps
`default_nettype none
module flash_program_protect_ctrl #(
	parameter int PROGRAM_US = 50,
	parameter int PAGE_ERASE_US = 25000,
	parameter int MASS_ERASE_US = 250000,
	parameter int COMMIT_US = 50
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic nv_blank,
	// Software register writes and violation clear
	input wire flash_ctrl_pkg::sw_write_t sw_wr,
	input wire logic viol_clear,
	// Software data reads
	input wire flash_ctrl_pkg::data_read_t rd_req,
	output flash_ctrl_pkg::read_answer_t rd_ans,
	// Register contents and status
	output logic [31:0] flash_addr_reg,
	output logic [31:0] flash_data_reg,
	output logic [3:0] flash_ctrl_reg,
	output logic [7:0] usec_reload,
	output logic access_violation_mask,
	output logic [3:0][31:0] block_read_enable,
	output logic [3:0][31:0] block_program_enable,
	output logic [1:0][31:0] user_word,
	output logic [31:0] debug_user_word,
	output logic prog_violation,
	output logic read_violation,
	output logic access_violation_irq,
	// Flash array
	output flash_ctrl_pkg::array_cmd_t arr_cmd,
	output logic [flash_ctrl_pkg::WORD_ADDR_W-1:0] arr_raddr,
	input wire logic [31:0] arr_rdata,
	input wire logic [31:0] arr_cur_data
);
	import flash_ctrl_pkg::*;

	typedef struct packed {
		seq_state_t state;
		logic [US_CNT_W-1:0] us_left;
		commit_target_t tgt;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] ctrl;
		logic [7:0] usec;
		logic mask;
		logic [3:0][31:0] rd_en;
		logic [3:0][31:0] pg_en;
		logic [1:0][31:0] user;
		logic [31:0] dbg;
		logic [3:0][31:0] nv_rd_en;
		logic [3:0][31:0] nv_pg_en;
		logic [1:0][31:0] nv_user;
		logic [31:0] nv_dbg;
		logic pviol;
		logic rviol;
		logic irq;
		logic rd_pend;
		logic rd_block;
		read_answer_t rd;
		array_cmd_t arr;
		logic [WORD_ADDR_W-1:0] raddr;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t next_s;
	logic tick;

	// ==========================================================
	// Microsecond timebase
	usec_tick u_tick (
		.mclk(mclk),
		.rst(rst),
		.reload(s.usec),
		.tick(tick)
	);

	// ==========================================================
	// Helpers
	function automatic logic block_bit(input logic [3:0][31:0] r, input logic [BLOCK_W-1:0] blk);
		return r[blk[6:5]][blk[4:0]];
	endfunction

	function automatic commit_target_t decode_target(input logic [31:0] a);
		commit_target_t t;
		t = '{valid: 1'b1, kind: TGT_RDEN, idx: 2'h0};
		if (a == COMMIT_RDEN0) t.idx = 2'h0;
		else if (a == COMMIT_RDEN1) t.idx = 2'h1;
		else if (a == COMMIT_RDEN2) t.idx = 2'h2;
		else if (a == COMMIT_RDEN3) t.idx = 2'h3;
		else if (a == COMMIT_PGEN0) t = '{valid: 1'b1, kind: TGT_PGEN, idx: 2'h0};
		else if (a == COMMIT_PGEN1) t = '{valid: 1'b1, kind: TGT_PGEN, idx: 2'h1};
		else if (a == COMMIT_PGEN2) t = '{valid: 1'b1, kind: TGT_PGEN, idx: 2'h2};
		else if (a == COMMIT_PGEN3) t = '{valid: 1'b1, kind: TGT_PGEN, idx: 2'h3};
		else if (a == COMMIT_USER0) t = '{valid: 1'b1, kind: TGT_USER, idx: 2'h0};
		else if (a == COMMIT_USER1) t = '{valid: 1'b1, kind: TGT_USER, idx: 2'h1};
		else if (a == COMMIT_DBG) t = '{valid: 1'b1, kind: TGT_DBG, idx: 2'h0};
		else t.valid = 1'b0;
		return t;
	endfunction

	logic key_ok;
	logic ctrl_wr;
	logic [BLOCK_W-1:0] addr_blk;
	logic pviol_set;
	logic rviol_set;
	assign key_ok = sw_wr.data[31:16] == CTRL_KEY;
	assign ctrl_wr = sw_wr.en && sw_wr.sel == SEL_CTRL;
	assign addr_blk = s.addr[BYTE_ADDR_W-1:BLOCK_LSB];

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.rd = '0;
		pviol_set = 1'b0;
		rviol_set = 1'b0;
		// Register writes; working copies cannot raise a committed zero
		if (sw_wr.en) begin
			if (sw_wr.sel == SEL_ADDR) next_s.addr = sw_wr.data;
			else if (sw_wr.sel == SEL_DATA) next_s.data = sw_wr.data;
			else if (sw_wr.sel == SEL_USEC) next_s.usec = sw_wr.data[7:0];
			else if (sw_wr.sel == SEL_MASK) next_s.mask = sw_wr.data[MASK_ACCESS];
			else if (sw_wr.sel == SEL_READEN) next_s.rd_en[sw_wr.idx] = sw_wr.data & s.nv_rd_en[sw_wr.idx];
			else if (sw_wr.sel == SEL_PROGEN) next_s.pg_en[sw_wr.idx] = sw_wr.data & s.nv_pg_en[sw_wr.idx];
			else if (sw_wr.sel == SEL_USER0) next_s.user[0] = sw_wr.data & s.nv_user[0];
			else if (sw_wr.sel == SEL_USER1) next_s.user[1] = sw_wr.data & s.nv_user[1];
		end
		// keyed start only, and only when idle
		if (ctrl_wr && key_ok && s.state == ST_IDLE) begin
			if (sw_wr.data[CTRL_WRITE]) begin
				if (block_bit(s.pg_en, addr_blk)) begin
					next_s.state = ST_PROG_RD;
					next_s.ctrl[CTRL_WRITE] = 1'b1;
					next_s.arr.word_addr = s.addr[BYTE_ADDR_W-1:2];
				end else begin
					pviol_set = 1'b1;
				end
			end else if (sw_wr.data[CTRL_ERASE]) begin
				if (block_bit(s.pg_en, addr_blk)) begin
					next_s.state = ST_ERASE;
					next_s.ctrl[CTRL_ERASE] = 1'b1;
					next_s.arr.page = s.addr[BYTE_ADDR_W-1:PAGE_LSB];
					next_s.arr.page_erase = 1'b1;
					next_s.us_left = US_CNT_W'(PAGE_ERASE_US);
				end else begin
					pviol_set = 1'b1;
				end
			end else if (sw_wr.data[CTRL_MASS]) begin
				// array-only mass erase, every block open
				if (&s.pg_en) begin
					next_s.state = ST_MASS;
					next_s.ctrl[CTRL_MASS] = 1'b1;
					next_s.arr.mass_erase = 1'b1;
					next_s.us_left = US_CNT_W'(MASS_ERASE_US);
				end else begin
					pviol_set = 1'b1;
				end
			end else if (sw_wr.data[CTRL_COMMIT]) begin
				next_s.tgt = decode_target(s.addr);
				if (next_s.tgt.valid) begin
					next_s.state = ST_COMMIT;
					next_s.ctrl[CTRL_COMMIT] = 1'b1;
					next_s.us_left = US_CNT_W'(COMMIT_US);
				end
			end
		end
		case (s.state)
			ST_PROG_RD: begin
				next_s.arr.wdata = arr_cur_data & s.data;
				next_s.arr.prog = 1'b1;
				next_s.us_left = US_CNT_W'(PROGRAM_US);
				next_s.state = ST_PROG;
			end
			ST_PROG, ST_ERASE, ST_MASS, ST_COMMIT: begin
				if (tick) begin
					next_s.us_left = s.us_left - US_CNT_W'(1);
					if (s.us_left <= US_CNT_W'(1)) begin
						next_s.state = ST_IDLE;
						next_s.ctrl = 4'h0;
						next_s.arr.prog = 1'b0;
						next_s.arr.page_erase = 1'b0;
						next_s.arr.mass_erase = 1'b0;
						if (s.state == ST_COMMIT) begin
							if (s.tgt.kind == TGT_RDEN) begin
								next_s.nv_rd_en[s.tgt.idx] = s.nv_rd_en[s.tgt.idx] & s.rd_en[s.tgt.idx];
							end else if (s.tgt.kind == TGT_PGEN) begin
								next_s.nv_pg_en[s.tgt.idx] = s.nv_pg_en[s.tgt.idx] & s.pg_en[s.tgt.idx];
							end else if (s.tgt.kind == TGT_USER) begin
								if (s.nv_user[s.tgt.idx[0]][NOT_WRITTEN_BIT]) begin
									next_s.nv_user[s.tgt.idx[0]] = s.nv_user[s.tgt.idx[0]] & s.user[s.tgt.idx[0]];
									next_s.nv_user[s.tgt.idx[0]][NOT_WRITTEN_BIT] = 1'b0;
									next_s.user[s.tgt.idx[0]] = next_s.nv_user[s.tgt.idx[0]];
								end
							end else if (s.nv_dbg[NOT_WRITTEN_BIT]) begin
								next_s.nv_dbg = s.nv_dbg & s.data;
								next_s.nv_dbg[NOT_WRITTEN_BIT] = 1'b0;
								next_s.dbg = next_s.nv_dbg;
							end
						end
					end
				end
			end
			default: begin
			end
		endcase
		// fetch always allowed; data read needs read enable
		if (s.rd_pend) begin
			next_s.rd.valid = 1'b1;
			next_s.rd.refused = s.rd_block;
			next_s.rd.data = s.rd_block ? 32'h0000_0000 : arr_rdata;
			rviol_set = s.rd_block;
		end
		next_s.rd_pend = rd_req.req;
		// block index from address bits 17:11
		next_s.rd_block = !rd_req.fetch && !block_bit(s.rd_en, rd_req.addr[BYTE_ADDR_W-1:BLOCK_LSB]);
		if (rd_req.req) next_s.raddr = rd_req.addr[BYTE_ADDR_W-1:2];
		// sticky status, set wins over clear
		next_s.pviol = (s.pviol && !viol_clear) || pviol_set;
		next_s.rviol = (s.rviol && !viol_clear) || rviol_set;
		next_s.irq = next_s.pviol && next_s.mask;
		if (rst) begin
			next_s.state = ST_IDLE;
			next_s.us_left = '0;
			next_s.tgt = '0;
			next_s.addr = 32'h0000_0000;
			next_s.data = 32'h0000_0000;
			next_s.ctrl = 4'h0;
			// timing for the top clock rate
			next_s.usec = USEC_RELOAD_RST;
			next_s.mask = 1'b0;
			// power-on reset reverts to committed values
			next_s.rd_en = s.nv_rd_en;
			next_s.pg_en = s.nv_pg_en;
			next_s.user = s.nv_user;
			next_s.dbg = s.nv_dbg;
			next_s.pviol = 1'b0;
			next_s.rviol = 1'b0;
			next_s.irq = 1'b0;
			next_s.rd_pend = 1'b0;
			next_s.rd_block = 1'b0;
			next_s.rd = '0;
			next_s.arr = '0;
			next_s.raddr = '0;
		end
		if (nv_blank) begin
			next_s.nv_rd_en = {PROT_REGS{PROT_RST}};
			next_s.nv_pg_en = {PROT_REGS{PROT_RST}};
			next_s.nv_user = {2{USER_RST}};
			next_s.nv_dbg = DBG_RST;
			next_s.rd_en = {PROT_REGS{PROT_RST}};
			next_s.pg_en = {PROT_REGS{PROT_RST}};
			next_s.user = {2{USER_RST}};
			next_s.dbg = DBG_RST;
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	// ==========================================================
	// Outputs
	assign rd_ans = s.rd;
	assign flash_addr_reg = s.addr;
	assign flash_data_reg = s.data;
	assign flash_ctrl_reg = s.ctrl;
	assign usec_reload = s.usec;
	assign access_violation_mask = s.mask;
	assign block_read_enable = s.rd_en;
	assign block_program_enable = s.pg_en;
	assign user_word = s.user;
	assign debug_user_word = s.dbg;
	assign prog_violation = s.pviol;
	assign read_violation = s.rviol;
	assign access_violation_irq = s.irq;
	assign arr_cmd = s.arr;
	assign arr_raddr = s.raddr;

	// ==========================================================
	// Assertions
	sequence keyed_start(int b);
		ctrl_wr && key_ok && sw_wr.data[b] && s.state == ST_IDLE;
	endsequence

	erase_page_sel_a: assert property (@(posedge mclk) disable iff (rst || nv_blank)
		keyed_start(CTRL_ERASE) ##0 (block_bit(s.pg_en, addr_blk) && !sw_wr.data[CTRL_WRITE])
		|=> arr_cmd.page_erase && arr_cmd.page == $past(s.addr[BYTE_ADDR_W-1:PAGE_LSB]))
		else $error("page erase not issued for addressed page");
	prog_clear_only_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(arr_cmd.prog) |-> (arr_cmd.wdata & ~$past(arr_cur_data)) == 32'h0000_0000)
		else $error("program would set a zero bit");
	blocked_write_a: assert property (@(posedge mclk) disable iff (rst || nv_blank)
		keyed_start(CTRL_WRITE) ##0 !block_bit(s.pg_en, addr_blk)
		|=> prog_violation && !flash_ctrl_reg[CTRL_WRITE] ##1 !arr_cmd.prog)
		else $error("program of protected block not blocked");
	read_zero_a: assert property (@(posedge mclk) disable iff (rst)
		rd_ans.refused |-> rd_ans.valid && rd_ans.data == 32'h0000_0000)
		else $error("refused read returned data");
	erase_busy_a: assert property (@(posedge mclk) disable iff (rst)
		s.state == ST_ERASE |-> flash_ctrl_reg[CTRL_ERASE] && arr_cmd.page_erase)
		else $error("erase bit low during erase");
	bad_key_a: assert property (@(posedge mclk) disable iff (rst)
		ctrl_wr && !key_ok && s.state == ST_IDLE |=> s.state == ST_IDLE)
		else $error("unkeyed control write started an operation");
	nv_only_clear_a: assert property (@(posedge mclk) disable iff (nv_blank)
		((s.nv_pg_en & ~$past(s.nv_pg_en)) == '0) && ((s.nv_rd_en & ~$past(s.nv_rd_en)) == '0))
		else $error("nonvolatile bit returned to one");
	user_once_a: assert property (@(posedge mclk) disable iff (nv_blank)
		!$past(s.nv_user[0][NOT_WRITTEN_BIT]) |-> $stable(s.nv_user[0]))
		else $error("user word committed twice");
	usec_reset_a: assert property (@(posedge mclk)
		rst && !sw_wr.en |=> usec_reload == USEC_RELOAD_RST)
		else $error("microsecond reload wrong after reset");
endmodule
`default_nettype wire

// [tb/flash_array_model.sv]
// Behavioural flash array answering the sequencer's commands
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
	// Clock
	input wire logic mclk,
	// Commands and read address
	input wire flash_ctrl_pkg::array_cmd_t arr_cmd,
	input wire logic [flash_ctrl_pkg::WORD_ADDR_W-1:0] arr_raddr,
	// Array data
	output logic [31:0] arr_rdata,
	output logic [31:0] arr_cur_data
);
	import flash_ctrl_pkg::*;

	logic [31:0] mem [0:65535];
	logic page_q = 1'b0;
	logic mass_q = 1'b0;

	assign arr_rdata = mem[arr_raddr];
	assign arr_cur_data = mem[arr_cmd.word_addr];

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 32'hffff_ffff;
		end
	end

	always @(posedge mclk) begin
		if (arr_cmd.prog) begin
			mem[arr_cmd.word_addr] <= mem[arr_cmd.word_addr] & arr_cmd.wdata;
		end
		if (arr_cmd.page_erase && !page_q) begin
			for (int i = 0; i < 256; i++) begin
				mem[{arr_cmd.page, 8'(i)}] <= 32'hffff_ffff;
			end
		end
		if (arr_cmd.mass_erase && !mass_q) begin
			for (int i = 0; i < 65536; i++) begin
				mem[i] <= 32'hffff_ffff;
			end
		end
		page_q <= arr_cmd.page_erase;
		mass_q <= arr_cmd.mass_erase;
	end
endmodule
`default_nettype wire

// [tb/flash_program_protect_ctrl_tb_top.sv]
// Self-checking testbench of the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_program_protect_ctrl_tb_top;
	import flash_ctrl_pkg::*;

	// ==========================================================
	// Signals
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic nv_blank = 1'b1;
	sw_write_t sw_wr = '0;
	logic viol_clear = 1'b0;
	data_read_t rd_req = '0;
	read_answer_t rd_ans;
	logic [31:0] flash_addr_reg, flash_data_reg, debug_user_word, arr_rdata, arr_cur_data;
	logic [3:0] flash_ctrl_reg;
	logic [7:0] usec_reload;
	logic access_violation_mask, prog_violation, read_violation, access_violation_irq;
	logic [3:0][31:0] block_read_enable, block_program_enable;
	logic [1:0][31:0] user_word;
	array_cmd_t arr_cmd;
	logic [WORD_ADDR_W-1:0] arr_raddr;
	int fails = 0;
	int samples_checked = 0;

	initial begin
		forever #2 mclk = ~mclk;
	end

	flash_program_protect_ctrl #(.PROGRAM_US(3), .PAGE_ERASE_US(20), .MASS_ERASE_US(30), .COMMIT_US(3)) i_dut (
		.mclk(mclk), .rst(rst), .nv_blank(nv_blank), .sw_wr(sw_wr), .viol_clear(viol_clear),
		.rd_req(rd_req), .rd_ans(rd_ans), .flash_addr_reg(flash_addr_reg), .flash_data_reg(flash_data_reg),
		.flash_ctrl_reg(flash_ctrl_reg), .usec_reload(usec_reload), .access_violation_mask(access_violation_mask),
		.block_read_enable(block_read_enable), .block_program_enable(block_program_enable),
		.user_word(user_word), .debug_user_word(debug_user_word), .prog_violation(prog_violation),
		.read_violation(read_violation), .access_violation_irq(access_violation_irq), .arr_cmd(arr_cmd),
		.arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_cur_data(arr_cur_data)
	);

	flash_array_model i_array (
		.mclk(mclk), .arr_cmd(arr_cmd), .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_cur_data(arr_cur_data)
	);

	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input reg_sel_t sel, input logic [1:0] idx, input logic [31:0] d);
		@(posedge mclk);
		sw_wr <= '{1'b1, sel, idx, d};
		@(posedge mclk);
		sw_wr.en <= 1'b0;
	endtask

	task automatic wait_idle;
		for (int n = 0; n < 400 && flash_ctrl_reg !== 4'h0; n++) begin
			@(posedge mclk);
			#1;
		end
		chk("idle", 32'h0, {28'h0, flash_ctrl_reg});
	endtask

	task automatic op(input logic [31:0] a, input int b, input logic go);
		wr(SEL_ADDR, 2'h0, a);
		wr(SEL_CTRL, 2'h0, {CTRL_KEY, 16'h0001 << b});
		#1;
		chk("busy bit", {31'h0, go}, {31'h0, flash_ctrl_reg[b]});
		wait_idle();
	endtask

	task automatic prog(input logic [31:0] a, input logic [31:0] d, input logic go);
		wr(SEL_DATA, 2'h0, d);
		op(a, CTRL_WRITE, go);
	endtask

	task automatic rd(input logic [17:0] a, input logic f, input logic [31:0] exp_d, input logic exp_ref);
		logic got;
		got = 1'b0;
		@(posedge mclk);
		rd_req <= '{1'b1, f, a};
		@(posedge mclk);
		rd_req.req <= 1'b0;
		repeat (4) begin
			#1;
			if (rd_ans.valid === 1'b1 && !got) begin
				chk("read data", exp_d, rd_ans.data);
				chk("refused", {31'h0, exp_ref}, {31'h0, rd_ans.refused});
				got = 1'b1;
			end
			@(posedge mclk);
		end
		chk("read answered", 32'h1, {31'h0, got});
	endtask

	task automatic do_reset;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		nv_blank <= 1'b0;
		@(posedge mclk);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk("usec reload", 32'hf9, {24'h0, usec_reload});
		for (int r = 0; r < 4; r++) begin
			chk("read enable", 32'hffff_ffff, block_read_enable[r]);
			chk("program enable", 32'hffff_ffff, block_program_enable[r]);
		end
		wr(SEL_USEC, 2'h0, 32'h3);
		#1;
		chk("usec written", 32'h3, {24'h0, usec_reload});
		$display("test reset done");
	endtask

	task automatic t_program;
		prog(32'h804, 32'h1234_5678, 1'b1);
		prog(32'h804, 32'hff00_ff00, 1'b1);
		rd(18'h804, 1'b0, 32'h1200_5600, 1'b0);
		wr(SEL_CTRL, 2'h0, 32'h1234_0001);
		repeat (2) @(posedge mclk);
		#1;
		chk("bad key", 32'h0, {28'h0, flash_ctrl_reg});
		$display("test program done");
	endtask

	task automatic t_erase;
		prog(32'hc00, 32'h0, 1'b1);
		op(32'h800, CTRL_ERASE, 1'b1);
		rd(18'h804, 1'b0, 32'hffff_ffff, 1'b0);
		rd(18'hc00, 1'b0, 32'h0, 1'b0);
		op(32'h0, CTRL_MASS, 1'b1);
		rd(18'hc00, 1'b0, 32'hffff_ffff, 1'b0);
		chk("debug word", 32'hffff_fffe, debug_user_word);
		chk("user word", 32'hffff_ffff, user_word[0]);
		$display("test erase done");
	endtask

	task automatic t_protect;
		wr(SEL_MASK, 2'h0, 32'h1);
		#1;
		chk("violation mask", 32'h1, {31'h0, access_violation_mask});
		wr(SEL_PROGEN, 2'h0, 32'hffff_fffd);
		for (int k = 0; k < 3; k++) begin
			op(32'h800, k, 1'b0);
			repeat (2) @(posedge mclk);
			#1;
			chk("prog violation", 32'h1, {31'h0, prog_violation});
			chk("violation irq", 32'h1, {31'h0, access_violation_irq});
			@(posedge mclk);
			viol_clear <= 1'b1;
			@(posedge mclk);
			viol_clear <= 1'b0;
			repeat (2) @(posedge mclk);
			#1;
			chk("violation cleared", 32'h0, {31'h0, prog_violation});
		end
		rd(18'h800, 1'b0, 32'hffff_ffff, 1'b0);
		wr(SEL_READEN, 2'h0, 32'hffff_fff9);
		rd(18'h800, 1'b0, 32'h0, 1'b1);
		chk("read violation", 32'h1, {31'h0, read_violation});
		rd(18'hc00, 1'b0, 32'h0, 1'b1);
		rd(18'h800, 1'b1, 32'hffff_ffff, 1'b0);
		prog(32'h1000, 32'h0f0f_0f0f, 1'b1);
		rd(18'h1000, 1'b1, 32'h0f0f_0f0f, 1'b0);
		rd(18'h1000, 1'b0, 32'h0, 1'b1);
		$display("test protect done");
	endtask

	task automatic t_commit;
		op(32'h1, CTRL_COMMIT, 1'b1);
		wr(SEL_USER0, 2'h0, 32'hffff_00ff);
		op(32'h8000_0000, CTRL_COMMIT, 1'b1);
		wr(SEL_DATA, 2'h0, 32'hffff_fff0);
		op(32'h7510_0000, CTRL_COMMIT, 1'b1);
		wr(SEL_USER0, 2'h0, 32'h0000_00ff);
		op(32'h8000_0000, CTRL_COMMIT, 1'b1);
		wr(SEL_USER1, 2'h0, 32'hfff0_ffff);
		op(32'h8000_0001, CTRL_COMMIT, 1'b1);
		wr(SEL_READEN, 2'h3, 32'h7fff_ffff);
		op(32'h8, CTRL_COMMIT, 1'b1);
		op(32'h6, CTRL_COMMIT, 1'b0);
		chk("address register", 32'h6, flash_addr_reg);
		chk("data register", 32'hffff_fff0, flash_data_reg);
		do_reset();
		chk("usec after reset", {24'h0, USEC_RELOAD_RST}, {24'h0, usec_reload});
		chk("user word 1", 32'h7ff0_ffff, user_word[1]);
		chk("committed read enable", 32'h7fff_ffff, block_read_enable[3]);
		chk("committed program enable", 32'hffff_fffd, block_program_enable[0]);
		chk("reverted read enable", 32'hffff_ffff, block_read_enable[0]);
		chk("user word once", 32'h7fff_00ff, user_word[0]);
		chk("debug word", 32'h7fff_fff0, debug_user_word);
		wr(SEL_PROGEN, 2'h0, 32'hffff_ffff);
		#1;
		chk("no set back", 32'hffff_fffd, block_program_enable[0]);
		$display("test commit done");
	endtask

	// ==========================================================
	// Sequence and verdict
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		$display("BAD watchdog expected finish seen hang");
		wrap_up();
	end

	initial begin
		do_reset();
		t_reset();
		t_program();
		t_erase();
		t_protect();
		t_commit();
		wrap_up();
	end
endmodule
`default_nettype wire
